// ### include/bga_pkg.sv
// Purpose: shared constants and types for the burst gate and auxiliary signalling block
// Assumes: one clock edge carries one bit, or two bits when the lanes are merged
// Notes:   merged-lane limits are the single-lane figures shifted left by one, except the marker offset (own value) and the divider limits (unshifted)
package bga_pkg;
    // ==================================================================
    // widths
    localparam int CW = 33;
    localparam int MW = 40;
    // ==================================================================
    // gate window, burst cycle, gap and delay limits, single lane
    localparam logic [CW-1:0] WIN_MIN       = 33'h000003200;
    localparam logic [CW-1:0] WIN_MAX_INT   = 33'h07ffffc00;
    localparam logic [CW-1:0] WIN_MAX_TRIG  = 33'h07fffff00;
    localparam logic [CW-1:0] CYC_MIN       = 33'h000006400;
    localparam logic [CW-1:0] CYC_MAX       = 33'h080000000;
    localparam logic [CW-1:0] WIN_STEP      = 33'h000000100;
    localparam logic [CW-1:0] GAP_MIN       = 33'h000000200;
    localparam logic [CW-1:0] DLY_MAX       = 33'h07ffffff8;
    localparam logic [CW-1:0] DLY_STEP      = 33'h000000008;
    // ==================================================================
    // auxiliary output limits
    localparam logic [9:0]    DIV_MIN       = 10'h004;
    localparam logic [9:0]    DIV_MAX       = 10'h200;
    localparam logic [MW-1:0] MARK_OFS      = 40'h0000000087;
    localparam logic [MW-1:0] MARK_OFS_M    = 40'h000000010f;
    localparam logic [MW-1:0] MARK_STEP     = 40'h0000000008;
    localparam logic [MW-1:0] EXT_LEN       = 40'h0000000200;
    localparam logic [MW-1:0] LCM_BASE_LOG  = 40'h0000000007;
    // ==================================================================
    // modes
    typedef enum logic [1:0] {SRC_INTERNAL, SRC_EXT_TRIGGER, SRC_EXT_ENABLE} bga_src_t;
    typedef enum logic [1:0] {AUXIN_BURST, AUXIN_MASK, AUXIN_CAPTURE} bga_func_t;
    typedef enum logic [1:0] {AUXOUT_DIVCLK, AUXOUT_MARKER, AUXOUT_LOCK, AUXOUT_ERROR} bga_out_t;
    typedef enum logic [2:0] {PAT_PRBS, PAT_ZERO_RUN, PAT_USER_DATA, PAT_MIXED, PAT_OTHER} bga_pat_t;
endpackage : bga_pkg

// ### include/bga_aux_if.sv
// Purpose: carries auxiliary output settings and status to the output generator
// Assumes: all signals on the bit clock
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
interface bga_aux_if;
    import bga_pkg::*;
    bga_out_t           mode;
    logic               merged;
    logic               mixed;
    logic [9:0]         divRatio;
    logic [31:0]        patternLen;
    logic [36:0]        markerPos;
    logic [15:0]        rowBits;
    logic [15:0]        rowsPerBlock;
    logic [15:0]        numBlocks;
    logic [15:0]        markerBlock;
    logic [15:0]        markerRow;
    logic               patternStart;
    logic               syncLock;
    logic               bitError;
    logic               auxOut;
    logic               setupError;
    modport src (output mode, merged, mixed, divRatio, patternLen, markerPos, rowBits, rowsPerBlock,
                 numBlocks, markerBlock, markerRow, patternStart, syncLock, bitError,
                 input auxOut, setupError);
    modport gen (input mode, merged, mixed, divRatio, patternLen, markerPos, rowBits, rowsPerBlock,
                 numBlocks, markerBlock, markerRow, patternStart, syncLock, bitError,
                 output auxOut, setupError);
endinterface : bga_aux_if
`default_nettype wire

// ### verilog/bga_aux_out.sv
// Purpose: auxiliary output generator: divided clock, pattern marker, lock, error
// Assumes: patternStart pulses at the first bit of each pattern period
// Notes:   marker counter aligns once per lock and then free-runs over the lcm period, or the block period for mixed patterns
`timescale 1ns/1ps
`default_nettype none
module bga_aux_out
    import bga_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   reset,
    bga_aux_if.gen      aux
);
    // ==================================================================
    // helpers
    function automatic logic [MW-1:0] extLen(input logic [MW-1:0] len, input logic [MW-1:0] thr);
        logic [MW-1:0] k;
        k = '0;
        if (len == '0 || len >= thr) begin
            extLen = len;
        end else begin
            k = (thr + len - 40'h1) / len;
            extLen = MW'(k * len);
        end
    endfunction : extLen

    function automatic logic [MW-1:0] lcm128(input logic [MW-1:0] len);
        logic [MW-1:0] sh;
        sh = LCM_BASE_LOG;
        for (int i = 0; i < 7; i++) begin
            if (len[i] && sh == LCM_BASE_LOG) begin
                sh = MW'(i);
            end
        end
        lcm128 = len << (LCM_BASE_LOG - sh);
    endfunction : lcm128

    // ==================================================================
    // marker period and position
    logic [MW-1:0] step, thr, ext, lcm, period, pos, ofs, mstep, markCnt_q;
    logic [9:0]    divCnt_q;
    logic          aligned_q, divClk_q, posBad, divBad, auxOut_q;

    assign step   = aux.merged ? 40'h2 : 40'h1;
    assign thr    = EXT_LEN << aux.merged;
    assign ext    = extLen(MW'(aux.patternLen), thr);
    assign lcm    = lcm128(ext);
    assign ofs    = aux.merged ? MARK_OFS_M : MARK_OFS;
    assign mstep  = MARK_STEP << aux.merged;
    assign period = aux.mixed ? MW'(aux.rowBits * aux.rowsPerBlock * aux.numBlocks) : lcm;
    assign pos    = aux.mixed ? MW'((aux.markerBlock * aux.rowsPerBlock + aux.markerRow) * aux.rowBits)
                              : MW'(aux.markerPos) - 40'h1;
    assign posBad = !aux.mixed && (aux.markerPos == '0 || MW'(aux.markerPos) + ofs > lcm
                    || ((MW'(aux.markerPos) - 40'h1) % mstep) != '0);
    assign divBad = aux.divRatio < DIV_MIN || aux.divRatio > DIV_MAX || aux.divRatio[0];
    assign aux.setupError = (aux.mode == AUXOUT_MARKER && posBad) || (aux.mode == AUXOUT_DIVCLK && divBad);
    assign aux.auxOut = auxOut_q;

    // ==================================================================
    // pattern counter, aligned to the first pattern start after lock
    always_ff @(posedge clk) begin
        if (reset || !aux.syncLock) begin
            aligned_q <= 1'b0;
            markCnt_q <= '0;
        end else if (!aligned_q && aux.patternStart) begin
            aligned_q <= 1'b1;
            markCnt_q <= step;
        end else if (markCnt_q + step >= period) begin
            markCnt_q <= '0;
        end else begin
            markCnt_q <= markCnt_q + step;
        end
    end

    // ==================================================================
    // divided clock; half period counted in bits
    always_ff @(posedge clk) begin
        if (reset || divBad) begin
            divCnt_q <= '0;
            divClk_q <= 1'b0;
        end else if (divCnt_q + 10'(step) >= (aux.divRatio >> 1)) begin
            divCnt_q <= '0;
            divClk_q <= !divClk_q;
        end else begin
            divCnt_q <= divCnt_q + 10'(step);
        end
    end

    // ==================================================================
    // output select
    always_ff @(posedge clk) begin
        if (reset) begin
            auxOut_q <= 1'b0;
        end else begin
            case (aux.mode)
                AUXOUT_DIVCLK: auxOut_q <= divClk_q;
                AUXOUT_MARKER: auxOut_q <= aligned_q && !posBad && pos >= markCnt_q
                                           && pos < markCnt_q + step;
                AUXOUT_LOCK:   auxOut_q <= aux.syncLock;
                AUXOUT_ERROR:  auxOut_q <= aux.bitError;
                default:       auxOut_q <= 1'b0;
            endcase
        end
    end
endmodule : bga_aux_out
`default_nettype wire

// ### verilog/bga_burst_gate.sv
// Purpose: receive-side burst gating, auxiliary input functions and auxiliary output
// Assumes: clk is the recovered bit clock; one bit per edge, two when lanes are merged
// Notes:   settings are plain ports and are expected static while a burst is running
// Functional notes
// - continuous and burst reception; burst for prbs, zero-run, user data, mixed.
// - internal source builds the gate from burst cycle and window lengths.
// - edge-started gate stays valid for the window length after aux rising edge.
// - level gating: data valid only while the auxiliary input is high.
// - blanking function suppresses measurement while the auxiliary input is low.
// - manual delay by programmed bits, 8-bit steps, 16 when merged.
// - automatic delay aligns the gate to the received pattern itself.
// - window length accepted within its range in 256-bit steps, 512 when merged.
// - burst cycle accepted within its range, 256 or 512-bit steps.
// - gap of at least 512 bits after the window, doubled when merged.
// - divided clock output at bit rate over even N from 4 to 512, N rounded up to a multiple of 4 when merged.
// - one marker pulse per lcm of the extended pattern and 128 bits, at programmed position, 8-bit steps.
// - merged lanes: marker limit lcm minus 271, 16-bit steps.
// - short patterns are repeated to reach 512 bits, 1024 when merged.
// - mixed patterns: one marker per block period at block and row.
// - lock output is high while pattern sync is established.
// - error output is high when a bit error is detected.
// - capture trigger from the auxiliary input when external source chosen.
// - external capture starts on the auxiliary input falling edge.
// - one auxiliary input setting serves both data channels.
`timescale 1ns/1ps
`default_nettype none
module bga_burst_gate
    import bga_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic                auxInPin,
    input  wire logic                seqBurst,
    input  wire bga_pkg::bga_src_t   gateSrc,
    input  wire bga_pkg::bga_func_t  auxInFunc,
    input  wire logic                captureExtSel,
    input  wire bga_pkg::bga_pat_t   patternKind,
    input  wire logic                dualLaneMerge,
    input  wire logic                delayAuto,
    input  wire logic [32:0]         delayBits,
    input  wire logic [32:0]         enablePeriod,
    input  wire logic [32:0]         burstCycle,
    input  wire logic                patternStart,
    input  wire logic                syncLock,
    input  wire logic                bitError,
    input  wire bga_pkg::bga_out_t   auxOutMode,
    input  wire logic [9:0]          divRatio,
    input  wire logic [31:0]         patternLen,
    input  wire logic [36:0]         markerPos,
    input  wire logic [15:0]         rowBits,
    input  wire logic [15:0]         rowsPerBlock,
    input  wire logic [15:0]         numBlocks,
    input  wire logic [15:0]         markerBlock,
    input  wire logic [15:0]         markerRow,
    output logic [1:0]               measEnable,
    output logic                     gateOpen,
    output logic                     captureStart,
    output logic                     cfgError,
    output logic                     auxOut
);
    import bga_pkg::*;

    // ==================================================================
    // helpers
    // true once the count plus this edge's bits reaches the limit
    function automatic logic reached(input logic [CW-1:0] cnt, input logic [CW-1:0] stp,
                                     input logic [CW-1:0] lim);
        reached = ({1'b0, cnt} + {1'b0, stp}) >= {1'b0, lim};
    endfunction : reached

    // value within [lo, hi] and a multiple of the step
    function automatic logic inRange(input logic [CW-1:0] v, input logic [CW-1:0] lo,
                                     input logic [CW-1:0] hi, input logic [CW-1:0] stp);
        inRange = v >= lo && v <= hi && (v % stp) == '0;
    endfunction : inRange

    typedef enum logic [1:0] {G_IDLE, G_DELAY, G_ALIGN, G_OPEN} bga_gate_t;

    // ==================================================================
    // auxiliary input synchroniser; meta flop feeds only the next flop
    logic auxMeta_q, auxSync_q, auxPrev_q, auxRise, auxFall;

    always_ff @(posedge clk) begin
        if (reset) begin
            auxMeta_q <= 1'b0;
            auxSync_q <= 1'b0;
            auxPrev_q <= 1'b0;
        end else begin
            auxMeta_q <= auxInPin;
            auxSync_q <= auxMeta_q;
            auxPrev_q <= auxSync_q;
        end
    end

    assign auxRise = auxSync_q && !auxPrev_q;
    assign auxFall = !auxSync_q && auxPrev_q;

    // ==================================================================
    // bit quantities per edge and merged-lane limits
    logic [CW-1:0] step, winStep, winMax, gapMin, dlyMax, dlyStep;
    logic [CW-1:0] winMin, cycMin, cycMax;

    assign step    = dualLaneMerge ? 33'h2 : 33'h1;
    assign winStep = WIN_STEP << dualLaneMerge;
    assign winMin  = WIN_MIN << dualLaneMerge;
    assign winMax  = (gateSrc == SRC_INTERNAL ? WIN_MAX_INT : WIN_MAX_TRIG) << dualLaneMerge;
    assign cycMin  = CYC_MIN << dualLaneMerge;
    assign cycMax  = CYC_MAX << dualLaneMerge;
    assign gapMin  = GAP_MIN << dualLaneMerge;
    assign dlyMax  = DLY_MAX << dualLaneMerge;
    assign dlyStep = DLY_STEP << dualLaneMerge;

    // ==================================================================
    // settings check; a bad burst setup keeps the gate shut
    logic patOk, winOk, cycOk, gapOk, dlyOk, auxFuncOk, cfgBad;

    assign patOk = patternKind == PAT_PRBS || patternKind == PAT_ZERO_RUN
                   || patternKind == PAT_USER_DATA || patternKind == PAT_MIXED;
    assign winOk = gateSrc == SRC_EXT_ENABLE
                   || inRange(enablePeriod, winMin, winMax, winStep);
    assign cycOk = gateSrc != SRC_INTERNAL
                   || inRange(burstCycle, cycMin, cycMax, winStep);
    // 34-bit sum so a window near the top of the range cannot wrap
    assign gapOk = gateSrc != SRC_INTERNAL
                   || ({1'b0, enablePeriod} + {1'b0, gapMin}) <= {1'b0, burstCycle};
    assign dlyOk = delayAuto || (delayBits <= dlyMax && (delayBits % dlyStep) == '0);
    assign auxFuncOk = gateSrc == SRC_INTERNAL || auxInFunc == AUXIN_BURST;
    assign cfgBad = seqBurst && !(patOk && winOk && cycOk && gapOk && dlyOk && auxFuncOk);

    // ==================================================================
    // internal gate generator: free-running burst cycle counter
    logic [CW-1:0] cycCnt_q;
    logic          intStart;

    always_ff @(posedge clk) begin
        if (reset || !seqBurst || gateSrc != SRC_INTERNAL || cfgBad) begin
            cycCnt_q <= '0;
        end else if (reached(cycCnt_q, step, burstCycle)) begin
            cycCnt_q <= '0;
        end else begin
            cycCnt_q <= cycCnt_q + step;
        end
    end

    assign intStart = seqBurst && gateSrc == SRC_INTERNAL && !cfgBad && cycCnt_q == '0;

    // ==================================================================
    // start and stop events of the valid window
    logic startEvt, levelMode, stopEvt;

    assign levelMode = gateSrc == SRC_EXT_ENABLE;
    always_comb begin
        case (gateSrc)
            SRC_INTERNAL:    startEvt = intStart;
            SRC_EXT_TRIGGER: startEvt = auxInFunc == AUXIN_BURST && auxRise;
            SRC_EXT_ENABLE:  startEvt = auxInFunc == AUXIN_BURST && auxRise;
            default:         startEvt = 1'b0;
        endcase
    end
    assign stopEvt = levelMode && auxInFunc == AUXIN_BURST && auxFall;

    // ==================================================================
    // gate sequencer: delay or pattern alignment, then the open window
    bga_gate_t     gState_q;
    logic [CW-1:0] dlyCnt_q, winCnt_q;
    logic          closeNow;

    always_ff @(posedge clk) begin
        if (reset || !seqBurst || cfgBad) begin
            gState_q <= G_IDLE;
            dlyCnt_q <= '0;
            winCnt_q <= '0;
        end else begin
            case (gState_q)
                G_IDLE: begin
                    dlyCnt_q <= '0;
                    winCnt_q <= '0;
                    if (startEvt) begin
                        if (delayAuto) begin
                            gState_q <= G_ALIGN;
                        end else if (delayBits == '0) begin
                            gState_q <= G_OPEN;
                        end else begin
                            gState_q <= G_DELAY;
                        end
                    end
                end
                G_DELAY: begin
                    dlyCnt_q <= dlyCnt_q + step;
                    if (reached(dlyCnt_q, step, delayBits)) begin
                        gState_q <= G_OPEN;
                    end
                end
                G_ALIGN: begin
                    // auto delay relies on framed sync so pattern starts are trustworthy
                    if (patternStart) begin
                        gState_q <= G_OPEN;
                    end
                end
                G_OPEN: begin
                    winCnt_q <= winCnt_q + step;
                    if (levelMode ? closeNow : reached(winCnt_q, step, enablePeriod)) begin
                        gState_q <= G_IDLE;
                    end
                end
                default: gState_q <= G_IDLE;
            endcase
        end
    end

    // ==================================================================
    // level gating: the falling edge gets the manual delay of the rising one; under auto delay it closes at once
    // limitation: only one pending fall is tracked; pulses shorter than the delay merge
    logic          closeArm_q;
    logic [CW-1:0] closeCnt_q;

    always_ff @(posedge clk) begin
        if (reset || gState_q == G_IDLE) begin
            closeArm_q <= 1'b0;
            closeCnt_q <= '0;
        end else if (stopEvt) begin
            closeArm_q <= 1'b1;
            closeCnt_q <= '0;
        end else if (closeArm_q && !closeNow) begin
            closeCnt_q <= closeCnt_q + step;
        end
    end

    assign closeNow = (stopEvt && (delayAuto || delayBits == '0))
                      || (closeArm_q && !delayAuto && reached(closeCnt_q, step, delayBits));

    // ==================================================================
    // measurement enable, shared by both channels
    bga_aux_if auxIf ();
    logic gate, blank;

    assign gate  = !seqBurst || gState_q == G_OPEN;
    assign blank = auxInFunc == AUXIN_MASK && !auxSync_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            measEnable <= '0;
            gateOpen   <= 1'b0;
            cfgError   <= 1'b0;
        end else begin
            measEnable <= {2{gate && !blank}};
            gateOpen   <= gate;
            cfgError   <= cfgBad || auxIf.setupError;
        end
    end

    // ==================================================================
    // external capture trigger
    always_ff @(posedge clk) begin
        if (reset) begin
            captureStart <= 1'b0;
        end else begin
            captureStart <= captureExtSel && auxInFunc == AUXIN_CAPTURE && auxFall;
        end
    end

    // ==================================================================
    // auxiliary output generator
    assign auxIf.mode         = auxOutMode;
    assign auxIf.merged       = dualLaneMerge;
    assign auxIf.mixed        = patternKind == PAT_MIXED;
    assign auxIf.divRatio     = divRatio;
    assign auxIf.patternLen   = patternLen;
    assign auxIf.markerPos    = markerPos;
    assign auxIf.rowBits      = rowBits;
    assign auxIf.rowsPerBlock = rowsPerBlock;
    assign auxIf.numBlocks    = numBlocks;
    assign auxIf.markerBlock  = markerBlock;
    assign auxIf.markerRow    = markerRow;
    assign auxIf.patternStart = patternStart;
    assign auxIf.syncLock     = syncLock;
    assign auxIf.bitError     = bitError;
    assign auxOut             = auxIf.auxOut;

    bga_aux_out uAuxOut (
        .clk   (clk),
        .reset (reset),
        .aux   (auxIf.gen)
    );
endmodule : bga_burst_gate
`default_nettype wire

// ### bench/bga_burst_gate_monitor.sv
// Purpose: port checks for the burst gate block
// Assumes: settings held steady while a check runs
// Notes: gate lengths are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module bga_burst_gate_monitor
    import bga_pkg::*;
(
    input wire logic               clk, reset, auxInPin, seqBurst, captureExtSel, syncLock, bitError, dualLaneMerge,
    input wire bga_pkg::bga_func_t auxInFunc,
    input wire bga_pkg::bga_out_t  auxOutMode,
    input wire logic [9:0]         divRatio,
    input wire logic [1:0]         measEnable,
    input wire logic               gateOpen, captureStart, cfgError, auxOut
);
    // ==========
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_lock_follow: assert property ((auxOutMode == AUXOUT_LOCK)[*2] |-> auxOut == $past(syncLock))
        else $error("lock lag");
    a_error_follow: assert property ((auxOutMode == AUXOUT_ERROR)[*2] |-> auxOut == $past(bitError))
        else $error("error lag");
    a_cont_open: assert property ((!seqBurst)[*4] |-> gateOpen) else $error("gate shut");
    a_mask_shut: assert property ((auxInFunc == AUXIN_MASK && !auxInPin)[*5] |-> measEnable == 2'h0)
        else $error("not masked");
    a_meas_pair: assert property (measEnable != 2'h0 |-> measEnable == 2'h3 && gateOpen)
        else $error("meas split");
    a_capture_once: assert property (captureStart |-> captureExtSel ##1 !captureStart)
        else $error("capture bad");
    a_cfg_shut: assert property ((cfgError && seqBurst)[*3] |-> !gateOpen) else $error("gate open");
    a_div_four: assert property ((auxOutMode == AUXOUT_DIVCLK && divRatio == 10'h004 && !dualLaneMerge)[*6]
        |-> auxOut != $past(auxOut, 2)) else $error("div bad");
    c_cap: cover property (captureStart);
    c_gate: cover property (seqBurst && $rose(gateOpen));
    c_cfg: cover property (cfgError);
endmodule : bga_burst_gate_monitor
bind bga_burst_gate bga_burst_gate_monitor u_bga_burst_gate_monitor (.clk, .reset, .auxInPin, .seqBurst,
    .captureExtSel, .syncLock, .bitError, .dualLaneMerge, .auxInFunc, .auxOutMode, .divRatio, .measEnable,
    .gateOpen, .captureStart, .cfgError, .auxOut);
`default_nettype wire

// ### bench/bga_far_side.sv
// Purpose: far side: aux input equipment and measured signal source
// Assumes: bench commands change just after a clock edge
// Notes: pattern period of 256 bits
`timescale 1ns/1ps
`default_nettype none
module bga_far_side (
    input wire logic clk, reset, pinLvl, lockOn, errOn,
    output logic     auxInPin, patternStart, syncLock, bitError
);
    logic [7:0] ph_q;
    // auto delay never asked for, so framed sync needs no model
    always_ff @(posedge clk) begin
        ph_q <= reset ? 8'h00 : ph_q + 8'h01;
        patternStart <= ph_q == 8'hff;
        auxInPin <= pinLvl;
        syncLock <= lockOn;
        bitError <= errOn & ph_q[0];
    end
endmodule : bga_far_side
`default_nettype wire

// ### bench/bga_burst_gate_tb.sv
// Purpose: self-checking bench for the burst gate block
// Assumes: single lane, one bit per edge, apart from the merged minimum-window check in t_bad
// Notes: minimum windows keep the run short
`timescale 1ns/1ps
`default_nettype none
module bga_burst_gate_tb;
    import bga_pkg::*;
    logic        clk, reset, seqBurst, captureExtSel, pinLvl, lockOn, errOn, auxInPin, patternStart, syncLock;
    logic        bitError, gateOpen, captureStart, cfgError, auxOut, dualLaneMerge, delayAuto;
    logic [1:0]  measEnable;
    logic [9:0]  divRatio;
    logic [31:0] patternLen;
    logic [36:0] markerPos;
    logic [32:0] delayBits, enablePeriod, burstCycle, c, t0, t1;
    bga_src_t    gateSrc;
    bga_pat_t    patternKind;
    bga_func_t   auxInFunc;
    bga_out_t    auxOutMode;
    int          fails, check_count;
    bga_far_side u_bga_far_side (.clk, .reset, .pinLvl, .lockOn, .errOn, .auxInPin, .patternStart, .syncLock,
        .bitError);
    bga_burst_gate u_bga_burst_gate (.clk, .reset, .auxInPin, .seqBurst, .gateSrc, .auxInFunc, .captureExtSel,
        .patternKind, .dualLaneMerge, .delayAuto, .delayBits, .enablePeriod, .burstCycle, .patternStart,
        .syncLock, .bitError, .auxOutMode, .divRatio, .patternLen, .markerPos, .rowBits(16'h0),
        .rowsPerBlock(16'h0), .numBlocks(16'h0), .markerBlock(16'h0),
        .markerRow(16'h0), .measEnable, .gateOpen, .captureStart, .cfgError, .auxOut);
    task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk
    task automatic cnt(ref logic s, input int len);
        c = 0;
        repeat (len) @(posedge clk) c = c + 33'(s);
    endtask : cnt
    task automatic waitg(input logic v);
        for (c = 0; gateOpen !== v && c < 33'h9c40; c++) @(posedge clk);
    endtask : waitg
    // mid-run reset between scenarios: starting from idle avoids half-open bursts
    task automatic cfg(input logic b, input bga_src_t s, input bga_func_t f, input logic [32:0] d);
        @(posedge clk) {reset, seqBurst, delayBits} <= {1'b1, b, d};
        gateSrc <= s;
        auxInFunc <= f;
        @(posedge clk) reset <= 0;
        repeat (5) @(posedge clk);
    endtask : cfg
    task automatic t_cont;
        pinLvl <= 1;
        cfg(0, SRC_INTERNAL, AUXIN_MASK, 0);
        chk("measEnable", 3, measEnable);
        pinLvl <= 0;
        repeat (8) @(posedge clk);
        chk("masked", 0, measEnable);
    endtask : t_cont
    task automatic t_int;
        cfg(1, SRC_INTERNAL, AUXIN_BURST, 0);
        waitg(1);
        cnt(gateOpen, 25600);
        chk("open per cycle", 12800, c);
    endtask : t_int
    task automatic t_trig(input logic [32:0] d);
        cfg(1, SRC_EXT_TRIGGER, AUXIN_BURST, d);
        pinLvl <= 1;
        waitg(1);
        t1 = c;
        waitg(0);
        chk("trigger window", 12800, c);
        pinLvl <= 0;
    endtask : t_trig
    task automatic t_en;
        cfg(1, SRC_EXT_ENABLE, AUXIN_BURST, 0);
        fork
            cnt(gateOpen, 400);
            begin
                pinLvl <= 1;
                repeat (300) @(posedge clk);
                pinLvl <= 0;
            end
        join
        chk("enable window", 300, c);
    endtask : t_en
    task automatic t_bad;
        enablePeriod <= 12801;
        cfg(1, SRC_INTERNAL, AUXIN_BURST, 0);
        chk("bad step", 1, cfgError);
        enablePeriod <= 25344;
        cfg(1, SRC_INTERNAL, AUXIN_BURST, 0);
        chk("short gap", 1, cfgError);
        enablePeriod <= 12800;
        dualLaneMerge <= 1;
        cfg(1, SRC_INTERNAL, AUXIN_BURST, 0);
        chk("merged min", 1, cfgError);
        dualLaneMerge <= 0;
        patternKind <= PAT_OTHER;
        cfg(1, SRC_INTERNAL, AUXIN_BURST, 0);
        chk("bad pattern", 1, cfgError);
    endtask : t_bad
    task automatic t_cap;
        for (int s = 0; s < 2; s++) begin
            {captureExtSel, pinLvl} <= {s[0], 1'b1};
            cfg(0, SRC_INTERNAL, AUXIN_CAPTURE, 0);
            pinLvl <= 0;
            cnt(captureStart, 12);
            chk("captures", 33'(s), c);
        end
    endtask : t_cap
    task automatic t_aux;
        auxOutMode <= AUXOUT_DIVCLK;
        cfg(0, SRC_INTERNAL, AUXIN_BURST, 0);
        cnt(auxOut, 40);
        chk("div high", 20, c);
        auxOutMode <= AUXOUT_LOCK;
        lockOn <= 1;
        repeat (4) @(posedge clk);
        chk("lock high", 1, auxOut);
        auxOutMode <= AUXOUT_ERROR;
        @(posedge clk);
        cnt(auxOut, 20);
        chk("error high", 10, c);
        auxOutMode <= AUXOUT_MARKER;
        repeat (700) @(posedge clk);
        cnt(auxOut, 1024);
        chk("markers", 2, c);
    endtask : t_aux
    task automatic results;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial begin
        {reset, seqBurst, captureExtSel, pinLvl, lockOn, errOn, dualLaneMerge, delayAuto} = 8'h84;
        {delayBits, enablePeriod, burstCycle} = {33'h0, 33'h3200, 33'h6400};
        {divRatio, patternLen, markerPos} = {10'h004, 32'h100, 37'h1};
        gateSrc = SRC_INTERNAL;
        auxInFunc = AUXIN_MASK;
        auxOutMode = AUXOUT_LOCK;
        patternKind = PAT_PRBS;
        repeat (6) @(posedge clk);
        reset <= 0;
        t_cont;
        t_int;
        t_trig(0);
        t0 = t1;
        t_trig(64);
        chk("delay edges", 64, t1 - t0);
        t_en;
        t_bad;
        t_cap;
        t_aux;
        results;
    end
    initial begin
        repeat (90000) @(posedge clk);
        fails++;
        results;
    end
endmodule : bga_burst_gate_tb
`default_nettype wire
